// File: flash_seq_defs.svh
// Constants of the flash command sequencer: register offsets, field positions,
// reset values, flash command bytes and timing counts.
// Assumes a 200 MHz system clock and a byte-wide flash on an asynchronous bus.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// Register offsets on the APB side
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0c

// Status register field positions
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_FAIL 2
`define STAT_WINDOW 3
`define STAT_SUSP 4
`define STAT_REJECT 5
`define STAT_TIMEOUT 6
`define STAT_LAST_LSB 8

// Reset values
`define ADDR_RST 19'h00000
`define DATA_RST 8'h00

// Flash status byte bit positions
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define TIMEOUT_BIT 5

// Flash command addresses and bytes
`define UNLOCK1_ADDR 19'h00555
`define UNLOCK2_ADDR 19'h002aa
`define UNLOCK1_DATA 8'haa
`define UNLOCK2_DATA 8'h55
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_PROGRAM 8'ha0
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hf0

// Timing: least times in ns round up to whole cycles
`define CLK_MHZ 200
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define T_AS_NS 10
`define T_WP_NS 50
`define T_WPH_NS 30
`define T_ACC_NS 120
`define T_RGAP_NS 30
`define T_AS_CYC `NS_TO_CYC(`T_AS_NS)
`define T_WP_CYC `NS_TO_CYC(`T_WP_NS)
`define T_WPH_CYC `NS_TO_CYC(`T_WPH_NS)
`define T_ACC_CYC `NS_TO_CYC(`T_ACC_NS)
`define T_RGAP_CYC `NS_TO_CYC(`T_RGAP_NS)
`define SYNC_CYC 2
// Sector load window, a longest time, rounds down
`define T_WINDOW_US 30
`define T_WINDOW_CYC (`T_WINDOW_US * `CLK_MHZ)
`define WINDOW_MARGIN_CYC 64

`endif

// File: flash_seq_pkg.sv
// Types of the flash command sequencer: operations, engine states, pin bundle.
// Assumes the constants header is included by the design file.
package flash_seq_pkg;

  // Operation codes as software writes them (position in the list)
  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
    OP_ADD_SECTOR, OP_SUSPEND, OP_RESUME, OP_RESET
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_W_SETUP, ST_W_PULSE, ST_W_HOLD, ST_R_ACC, ST_R_GAP, ST_WINDOW
  } state_e;

  // Flash pins driven by the controller
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [18:0] addr;
    logic [7:0] dq_out;
    logic dq_oe_n;
  } flash_pins_s;

endpackage : flash_seq_pkg

// File: flash_erase_program_sequencer.sv
// Host-side command sequencer for a byte-wide parallel flash: issues unlock,
// program, erase, suspend, resume and reset sequences and polls status bits.
// Assumes an APB master on sys_clk and a flash whose data pins return
// asynchronously; the board resolves dq from dq_out and dq_oe_n.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

module flash_erase_program_sequencer #(
  parameter int unsigned WINDOW_CYC = `T_WINDOW_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output flash_seq_pkg::flash_pins_s pins,
  input wire logic [7:0] dq_in
);

  localparam logic [15:0] AS_LD = 16'(`T_AS_CYC - 1);
  localparam logic [15:0] WP_LD = 16'(`T_WP_CYC - 1);
  localparam logic [15:0] WPH_LD = 16'(`T_WPH_CYC - 1);
  localparam logic [15:0] ACC_LD = 16'(`T_ACC_CYC + `SYNC_CYC - 1);
  localparam logic [15:0] RGAP_LD = 16'(`T_RGAP_CYC - 1);
  localparam logic [19:0] WIN_END = 20'(WINDOW_CYC);
  localparam logic [19:0] WIN_ADD = 20'(WINDOW_CYC - `WINDOW_MARGIN_CYC);

  // Address and data of one command write
  function automatic logic [26:0] step_of(flash_seq_pkg::op_e op, logic [2:0] idx,
                                          logic [18:0] a, logic [7:0] d);
    logic [18:0] sa;
    logic [7:0] sd;
    sa = 19'h00000;
    sd = 8'h00;
    case (op)
      flash_seq_pkg::OP_SUSPEND: sd = `CMD_SUSPEND;
      flash_seq_pkg::OP_RESUME: sd = `CMD_RESUME;
      flash_seq_pkg::OP_RESET: sd = `CMD_RESET;
      flash_seq_pkg::OP_ADD_SECTOR: begin
        sa = a;
        sd = `CMD_SECTOR_ERASE;
      end
      default: begin
        case (idx)
          3'd0, 3'd3: begin
            sa = `UNLOCK1_ADDR;
            sd = `UNLOCK1_DATA;
          end
          3'd1, 3'd4: begin
            sa = `UNLOCK2_ADDR;
            sd = `UNLOCK2_DATA;
          end
          3'd2: begin
            sa = `UNLOCK1_ADDR;
            sd = (op == flash_seq_pkg::OP_PROGRAM) ? `CMD_PROGRAM : `CMD_ERASE_SETUP;
          end
          default: begin
            sa = `UNLOCK1_ADDR;
            sd = `CMD_CHIP_ERASE;
            if (op == flash_seq_pkg::OP_SECTOR_ERASE) begin
              sa = a;
              sd = `CMD_SECTOR_ERASE;
            end
          end
        endcase
        if (op == flash_seq_pkg::OP_PROGRAM && idx == 3'd3) begin
          sa = a;
          sd = d;
        end
      end
    endcase
    return {sa, sd};
  endfunction : step_of

  // Index of the last write of each operation
  function automatic logic [2:0] last_step(flash_seq_pkg::op_e op);
    case (op)
      flash_seq_pkg::OP_PROGRAM: last_step = 3'd3;
      flash_seq_pkg::OP_CHIP_ERASE, flash_seq_pkg::OP_SECTOR_ERASE: last_step = 3'd5;
      default: last_step = 3'd0;
    endcase
  endfunction : last_step

  flash_seq_pkg::state_e state_r, state_nxt;
  flash_seq_pkg::op_e op_r, op_nxt, pend_r, pend_nxt;
  flash_seq_pkg::flash_pins_s pins_r, pins_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [19:0] win_r, win_nxt;
  logic [2:0] step_r, step_nxt;
  logic [18:0] addr_reg_r, addr_reg_nxt, op_addr_r, op_addr_nxt;
  logic [7:0] data_reg_r, data_reg_nxt, op_data_r, op_data_nxt;
  logic [7:0] prev_r, prev_nxt, last_r, last_nxt;
  logic polling_r, polling_nxt, first_r, first_nxt, q5_r, q5_nxt;
  logic done_r, done_nxt, fail_r, fail_nxt, susp_r, susp_nxt;
  logic rej_r, rej_nxt, tmo_r, tmo_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [7:0] dq_s1_r, dq_s2_r;
  logic [31:0] status_word;
  logic sector_op;

  assign status_word = {16'h0000, last_r, 1'b0, tmo_r, rej_r, susp_r,
                        state_r == flash_seq_pkg::ST_WINDOW, fail_r, done_r,
                        state_r != flash_seq_pkg::ST_IDLE};
  assign sector_op = op_r == flash_seq_pkg::OP_SECTOR_ERASE ||
                     op_r == flash_seq_pkg::OP_ADD_SECTOR ||
                     op_r == flash_seq_pkg::OP_RESUME;

  // Data pins cross from the flash's asynchronous timing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // Next values of bus slave, command engine and pins
  always_comb begin
    flash_seq_pkg::op_e take;
    logic [26:0] st;
    logic acc;
    take = flash_seq_pkg::OP_NONE;
    st = 27'h0;
    acc = psel && penable && pready_r;
    state_nxt = state_r;
    op_nxt = op_r;
    pend_nxt = pend_r;
    cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
    win_nxt = win_r;
    step_nxt = step_r;
    addr_reg_nxt = addr_reg_r;
    data_reg_nxt = data_reg_r;
    op_addr_nxt = op_addr_r;
    op_data_nxt = op_data_r;
    prev_nxt = prev_r;
    last_nxt = last_r;
    polling_nxt = polling_r;
    first_nxt = first_r;
    q5_nxt = q5_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    susp_nxt = susp_r;
    rej_nxt = rej_r;
    tmo_nxt = tmo_r;
    // Answer in the first access cycle; data fixed during setup
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      case (paddr)
        `REG_CMD: prdata_nxt = {28'h0000000, pend_r};
        `REG_ADDR: prdata_nxt = {13'h0000, addr_reg_r};
        `REG_DATA: prdata_nxt = {24'h000000, data_reg_r};
        `REG_STATUS: prdata_nxt = status_word;
        default: begin
          prdata_nxt = 32'h00000000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        `REG_ADDR: addr_reg_nxt = pwdata[18:0];
        `REG_DATA: data_reg_nxt = pwdata[7:0];
        `REG_CMD: begin
          // One order may wait; a second or unknown one is refused
          if (pend_r == flash_seq_pkg::OP_NONE && pwdata[3:0] != 4'h0 &&
              pwdata[3:0] <= 4'h8) begin
            pend_nxt = flash_seq_pkg::op_e'(pwdata[3:0]);
          end else begin
            rej_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    case (state_r)
      flash_seq_pkg::ST_IDLE: begin
        if (pend_r != flash_seq_pkg::OP_NONE) begin
          pend_nxt = flash_seq_pkg::OP_NONE;
          if (susp_r) begin
            if (pend_r == flash_seq_pkg::OP_READ || pend_r == flash_seq_pkg::OP_PROGRAM ||
                pend_r == flash_seq_pkg::OP_RESUME) begin
              take = pend_r;
            end else begin
              rej_nxt = 1'b1;
            end
          end else if (pend_r == flash_seq_pkg::OP_ADD_SECTOR ||
                       pend_r == flash_seq_pkg::OP_SUSPEND ||
                       pend_r == flash_seq_pkg::OP_RESUME) begin
            rej_nxt = 1'b1;
          end else begin
            take = pend_r;
          end
        end
      end
      flash_seq_pkg::ST_W_SETUP: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = flash_seq_pkg::ST_W_PULSE;
          cnt_nxt = WP_LD;
        end
      end
      flash_seq_pkg::ST_W_PULSE: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = flash_seq_pkg::ST_W_HOLD;
          cnt_nxt = WPH_LD;
        end
      end
      flash_seq_pkg::ST_W_HOLD: begin
        if (cnt_r == 16'h0000) begin
          if (step_r != last_step(op_r)) begin
            step_nxt = step_r + 3'd1;
            state_nxt = flash_seq_pkg::ST_W_SETUP;
            cnt_nxt = AS_LD;
          end else begin
            case (op_r)
              flash_seq_pkg::OP_SECTOR_ERASE, flash_seq_pkg::OP_ADD_SECTOR: begin
                state_nxt = flash_seq_pkg::ST_WINDOW;
                win_nxt = 20'h00000;
              end
              flash_seq_pkg::OP_SUSPEND: begin
                susp_nxt = 1'b1;
                done_nxt = 1'b1;
                state_nxt = flash_seq_pkg::ST_IDLE;
              end
              flash_seq_pkg::OP_RESET: begin
                done_nxt = 1'b1;
                state_nxt = flash_seq_pkg::ST_IDLE;
              end
              default: begin
                // Status is valid right after the last write
                if (op_r == flash_seq_pkg::OP_RESUME) begin
                  susp_nxt = 1'b0;
                end
                polling_nxt = 1'b1;
                first_nxt = 1'b1;
                q5_nxt = 1'b0;
                state_nxt = flash_seq_pkg::ST_R_ACC;
                cnt_nxt = ACC_LD;
              end
            endcase
          end
        end
      end
      flash_seq_pkg::ST_R_ACC: begin
        if (cnt_r == 16'h0000) begin
          last_nxt = dq_s2_r;
          state_nxt = flash_seq_pkg::ST_R_GAP;
          cnt_nxt = RGAP_LD;
          if (!polling_r) begin
            done_nxt = 1'b1;
          end else if (first_r) begin
            prev_nxt = dq_s2_r;
            first_nxt = 1'b0;
          end else if (dq_s2_r[`TOGGLE_BIT] == prev_r[`TOGGLE_BIT]) begin
            // Toggle steady over two reads: operation over
            polling_nxt = 1'b0;
            done_nxt = 1'b1;
            if (op_r == flash_seq_pkg::OP_PROGRAM) begin
              fail_nxt = dq_s2_r[7:6] != op_data_r[7:6];
            end else begin
              fail_nxt = !dq_s2_r[`POLL_BIT];
            end
          end else begin
            prev_nxt = dq_s2_r;
            if (dq_s2_r[`TIMEOUT_BIT]) begin
              // Toggle may stop just as the flag rises: one more pair
              tmo_nxt = 1'b1;
              if (q5_r) begin
                polling_nxt = 1'b0;
                done_nxt = 1'b1;
                fail_nxt = 1'b1;
              end else begin
                q5_nxt = 1'b1;
                first_nxt = 1'b1;
              end
            end
          end
        end
      end
      flash_seq_pkg::ST_R_GAP: begin
        if (cnt_r == 16'h0000) begin
          if (!polling_r) begin
            state_nxt = flash_seq_pkg::ST_IDLE;
          end else if (sector_op && pend_r == flash_seq_pkg::OP_SUSPEND) begin
            pend_nxt = flash_seq_pkg::OP_NONE;
            polling_nxt = 1'b0;
            take = flash_seq_pkg::OP_SUSPEND;
          end else begin
            state_nxt = flash_seq_pkg::ST_R_ACC;
            cnt_nxt = ACC_LD;
          end
        end
      end
      flash_seq_pkg::ST_WINDOW: begin
        win_nxt = win_r + 20'h00001;
        if (pend_r == flash_seq_pkg::OP_ADD_SECTOR && win_r < WIN_ADD) begin
          pend_nxt = flash_seq_pkg::OP_NONE;
          take = flash_seq_pkg::OP_ADD_SECTOR;
        end else if (pend_r == flash_seq_pkg::OP_SUSPEND) begin
          pend_nxt = flash_seq_pkg::OP_NONE;
          take = flash_seq_pkg::OP_SUSPEND;
        end else if (pend_r != flash_seq_pkg::OP_NONE) begin
          // Anything else here would abort the erase in the flash
          pend_nxt = flash_seq_pkg::OP_NONE;
          rej_nxt = 1'b1;
        end else if (win_r >= WIN_END) begin
          polling_nxt = 1'b1;
          first_nxt = 1'b1;
          q5_nxt = 1'b0;
          state_nxt = flash_seq_pkg::ST_R_ACC;
          cnt_nxt = ACC_LD;
        end
      end
      default: state_nxt = flash_seq_pkg::ST_IDLE;
    endcase
    // Launch an accepted order
    if (take != flash_seq_pkg::OP_NONE) begin
      op_nxt = take;
      step_nxt = 3'd0;
      done_nxt = 1'b0;
      fail_nxt = 1'b0;
      // A command refused in this same cycle keeps its flag
      rej_nxt = acc && pwrite && paddr == `REG_CMD;
      tmo_nxt = 1'b0;
      if (take != flash_seq_pkg::OP_SUSPEND) begin
        op_addr_nxt = addr_reg_r;
        op_data_nxt = data_reg_r;
      end
      if (take == flash_seq_pkg::OP_READ) begin
        state_nxt = flash_seq_pkg::ST_R_ACC;
        cnt_nxt = ACC_LD;
      end else begin
        state_nxt = flash_seq_pkg::ST_W_SETUP;
        cnt_nxt = AS_LD;
      end
    end
    // Pins follow the next state
    st = step_of(op_nxt, step_nxt, op_addr_nxt, op_data_nxt);
    pins_nxt = pins_r;
    pins_nxt.ce_n = 1'b1;
    pins_nxt.we_n = 1'b1;
    pins_nxt.oe_n = 1'b1;
    pins_nxt.dq_oe_n = 1'b1;
    case (state_nxt)
      flash_seq_pkg::ST_W_SETUP, flash_seq_pkg::ST_W_PULSE, flash_seq_pkg::ST_W_HOLD: begin
        pins_nxt.ce_n = 1'b0;
        pins_nxt.we_n = state_nxt != flash_seq_pkg::ST_W_PULSE;
        pins_nxt.dq_oe_n = 1'b0;
        pins_nxt.addr = st[26:8];
        pins_nxt.dq_out = st[7:0];
      end
      flash_seq_pkg::ST_R_ACC: begin
        pins_nxt.ce_n = 1'b0;
        pins_nxt.oe_n = 1'b0;
        pins_nxt.addr = op_addr_nxt;
      end
      default: ;
    endcase
  end

  // Register all state but the data pin synchronizer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= flash_seq_pkg::ST_IDLE;
      op_r <= flash_seq_pkg::OP_NONE;
      pend_r <= flash_seq_pkg::OP_NONE;
      pins_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: `ADDR_RST,
                  dq_out: `DATA_RST, dq_oe_n: 1'b1};
      cnt_r <= 16'h0000;
      win_r <= 20'h00000;
      step_r <= 3'h0;
      addr_reg_r <= `ADDR_RST;
      data_reg_r <= `DATA_RST;
      op_addr_r <= `ADDR_RST;
      op_data_r <= `DATA_RST;
      prev_r <= 8'h00;
      last_r <= 8'h00;
      {polling_r, first_r, q5_r, done_r, fail_r, susp_r, rej_r, tmo_r} <= 8'h00;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      pend_r <= pend_nxt;
      pins_r <= pins_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      step_r <= step_nxt;
      addr_reg_r <= addr_reg_nxt;
      data_reg_r <= data_reg_nxt;
      op_addr_r <= op_addr_nxt;
      op_data_r <= op_data_nxt;
      prev_r <= prev_nxt;
      last_r <= last_nxt;
      {polling_r, first_r, q5_r, done_r, fail_r, susp_r, rej_r, tmo_r} <=
        {polling_nxt, first_nxt, q5_nxt, done_nxt, fail_nxt, susp_nxt, rej_nxt, tmo_nxt};
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pins = pins_r;

endmodule : flash_erase_program_sequencer

// File: flash_seq_properties.sv
// Checker of the flash sequencer: bus answer and flash pin timing.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
module flash_seq_properties #(
  parameter int unsigned WINDOW_CYC = 6000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input wire flash_seq_pkg::flash_pins_s pins,
  input wire logic [7:0] dq_in
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Strobe low ten cycles, then high
  sequence s_strobe;
    (!pins.we_n)[*8] ##1 (!pins.we_n)[*2] ##1 pins.we_n;
  endsequence
  property p_gate;
    !pins.we_n |-> !pins.ce_n && pins.oe_n;
  endproperty
  a_gate: assert property (p_gate) else $error("strobe without select");
  property p_contend;
    !pins.oe_n |-> pins.dq_oe_n && pins.we_n;
  endproperty
  a_contend: assert property (p_contend) else $error("data bus contention");
  property p_strobe;
    $fell(pins.we_n) |-> s_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width wrong");
  property p_stable;
    $fell(pins.we_n) |-> ($stable(pins.addr) && $stable(pins.dq_out))[*8];
  endproperty
  a_stable: assert property (p_stable) else $error("address or data moved");
  property p_hold;
    $rose(pins.we_n) |-> (!pins.ce_n && !pins.dq_oe_n)[*6];
  endproperty
  a_hold: assert property (p_hold) else $error("write hold too short");
  property p_unlock;
    $fell(pins.we_n) && pins.dq_out == 8'h55 |-> pins.addr == 19'h002aa;
  endproperty
  a_unlock: assert property (p_unlock) else $error("second unlock address");
  property p_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  property p_upper;
    psel && !penable && !pwrite && paddr == 8'h0c |=> pready && !pslverr && prdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("status upper bits set");
endmodule : flash_seq_properties

// File: flash_device_model.sv
// Behavioural byte-wide flash: command decoder, embedded ops, status bits.
// Assumes the sequencer pins; busy time is counted in status reads.
`timescale 1ns/1ps
module flash_device_model #(
  parameter int WIN_NS = 30000
) (
  // Controller pins and scenario switch for a stuck operation
  input wire flash_seq_pkg::flash_pins_s pins,
  input wire logic fail_mode,
  // Data pins back
  output logic [7:0] dq
);
  typedef enum logic [1:0] {M_READ, M_ARM, M_BUSY, M_WIN} mode_e;
  mode_e mode = M_READ;
  logic [7:0] mem[int];
  int secs[$];
  int ucnt = 0;
  int left = 0;
  int last_n = 0;
  bit setup = 0, erase = 0, chip = 0, susp = 0, tog = 0, stog = 0;
  logic [18:0] a = '0;
  logic [7:0] pd = '0, q = '0;
  realtime t_last = 0;
  wire idle = (mode == M_READ);
  wire wr_n = pins.ce_n | pins.we_n | ~pins.oe_n;
  wire rd_n = pins.ce_n | pins.oe_n;
  wire [7:0] din = pins.dq_oe_n ? 8'hff : pins.dq_out;
  // Released bus shows the inverse, never a stale byte
  assign dq = rd_n ? ~q : q;
  function automatic logic [7:0] peek(int k);
    return mem.exists(k) ? mem[k] : 8'hff;
  endfunction : peek
  task automatic start(bit e, int n);
    mode = M_BUSY;
    erase = e;
    left = n;
    ucnt = 0;
    setup = 0;
  endtask : start
  // Window closes lazily once no select came in time
  task automatic upd();
    if (mode == M_WIN && $realtime - t_last >= WIN_NS) start(1, 3);
  endtask : upd
  always @(negedge wr_n) a = pins.addr;
  // Byte taken on the earlier rising edge
  always @(posedge wr_n) begin
    upd();
    if (mode == M_WIN) begin
      if (din == 8'h30) secs.push_back(a[18:16]);
      t_last = $realtime;
      if (din != 8'h30) mode = M_READ;
      susp = (din == 8'hb0);
    end else if (mode == M_BUSY) begin
      if (erase && !chip && din == 8'hb0) susp = 1;
      if ((erase && !chip && din == 8'hb0) || (fail_mode && din == 8'hf0)) mode = M_READ;
    end else if (mode == M_ARM) begin
      pd = din;
      mem[a] = peek(a) & din;
      start(0, 3);
    end else if (susp && din == 8'h30) begin
      susp = 0;
      start(1, 3);
    end else if (ucnt == 2) begin
      // Third write of a group is the command byte
      ucnt = 0;
      if (!setup && din == 8'ha0) mode = M_ARM;
      else if (!setup && !susp && din == 8'h80) setup = 1;
      else if (setup && din == 8'h10) chip = 1;
      else if (setup && din == 8'h30) begin
        chip = 0;
        secs = {a[18:16]};
        mode = M_WIN;
        t_last = $realtime;
      end
      if (din != 8'h80) setup = 0;
    end else if (ucnt == 0 && a[10:0] == 11'h555 && din == 8'haa) ucnt = 1;
    else if (ucnt == 1 && a[10:0] == 11'h2aa && din == 8'h55) ucnt = 2;
    else begin
      // A stray write drops back to plain reads
      ucnt = 0;
      setup = 0;
    end
    if (chip && mode == M_READ) start(1, 4);
  end
  // Wipe the erased cells at completion
  task automatic finish_op();
    int ks[$];
    foreach (mem[k]) if (erase && (chip || (k >> 16) inside {secs})) ks.push_back(k);
    foreach (ks[i]) mem.delete(ks[i]);
    last_n = secs.size();
    if (erase) secs.delete();
    chip = 0;
    mode = M_READ;
  endtask : finish_op
  // Status while busy or loading, array data otherwise
  always @(negedge rd_n) begin
    upd();
    if (mode == M_BUSY && left <= 0 && !fail_mode) finish_op();
    tog = ~tog;
    stog = stog ^ erase;
    left = left - 1;
    if (mode == M_BUSY && erase) q = {1'b0, tog, fail_mode, 1'b0, 1'b1, stog, 2'b0};
    else if (mode == M_BUSY) q = {~pd[7], tog, fail_mode, 5'b0};
    else if (mode == M_WIN) q = {1'b0, tog, 3'b0, stog, 2'b0};
    else q = peek(pins.addr);
  end
endmodule : flash_device_model

// File: flash_erase_program_sequencer_bench.sv
// Bench of the flash sequencer: APB orders against a flash model.
// Assumes the design, its package and the checker are compiled first.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module flash_erase_program_sequencer_bench;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, fail_mode;
  logic [7:0] paddr, dq_in;
  logic [31:0] pwdata, prdata, rd;
  flash_seq_pkg::flash_pins_s pins;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  // Short load window keeps the run brief
  flash_erase_program_sequencer #(.WINDOW_CYC(200)) u_flash_erase_program_sequencer (
    .sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .dq_in(dq_in));
  flash_device_model #(.WIN_NS(900)) u_flash_device_model (.pins(pins),
    .fail_mode(fail_mode), .dq(dq_in));
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task check(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // One APB transfer; answer taken at the pready edge
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task order(flash_seq_pkg::op_e op, logic [18:0] a, logic [7:0] d);
    apb(1, `REG_ADDR, {13'h0, a});
    apb(1, `REG_DATA, {24'h0, d});
    apb(1, `REG_CMD, {28'h0, op});
  endtask : order
  // Poll status, bounded, until a flag rises
  task wait_flag(int b);
    rd = '0;
    for (int i = 0; i < 400 && rd[b] !== 1'b1; i++) apb(0, `REG_STATUS, 32'h0);
  endtask : wait_flag
  task run(flash_seq_pkg::op_e op, logic [18:0] a, logic [7:0] d, logic f);
    order(op, a, d);
    wait_flag(`STAT_DONE);
    check("done", 32'h1, 32'(rd[`STAT_DONE]));
    check("fail", 32'(f), 32'(rd[`STAT_FAIL]));
  endtask : run
  initial begin
    {arst_n, psel, penable, pwrite, fail_mode, err} = '0;
    {paddr, pwdata, rd} = '0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1;
    apb(0, `REG_STATUS, 32'h0);
    check("status_rst", 32'h0, rd);
    apb(1, 8'h10, 32'h1);
    check("unmapped_err", 32'h1, 32'(err));
    $display("test registers done");
    run(flash_seq_pkg::OP_PROGRAM, 19'h01234, 8'h3c, 0);
    check("prog_cell", 32'h3c, 32'(u_flash_device_model.peek(32'h01234)));
    run(flash_seq_pkg::OP_READ, 19'h01234, 8'h0, 0);
    check("read_back", 32'h3c, 32'(rd[15:8]));
    run(flash_seq_pkg::OP_CHIP_ERASE, 19'h0, 8'h0, 0);
    check("chip_erased", 32'hff, 32'(u_flash_device_model.peek(32'h01234)));
    $display("test program and chip erase done");
    run(flash_seq_pkg::OP_PROGRAM, 19'h20010, 8'h11, 0);
    order(flash_seq_pkg::OP_SECTOR_ERASE, 19'h20000, 8'h0);
    wait_flag(`STAT_WINDOW);
    check("window", 32'h1, 32'(rd[`STAT_WINDOW]));
    run(flash_seq_pkg::OP_ADD_SECTOR, 19'h30000, 8'h0, 0);
    check("sectors", 32'h2, 32'(u_flash_device_model.last_n));
    check("sector_erased", 32'hff, 32'(u_flash_device_model.peek(32'h20010)));
    $display("test sector erase done");
    run(flash_seq_pkg::OP_PROGRAM, 19'h40020, 8'h22, 0);
    order(flash_seq_pkg::OP_SECTOR_ERASE, 19'h40000, 8'h0);
    wait_flag(`STAT_WINDOW);
    run(flash_seq_pkg::OP_SUSPEND, 19'h40000, 8'h0, 0);
    check("suspended", 32'h1, 32'(u_flash_device_model.susp));
    check("kept", 32'h22, 32'(u_flash_device_model.peek(32'h40020)));
    run(flash_seq_pkg::OP_PROGRAM, 19'h60000, 8'h5a, 0);
    check("susp_prog", 32'h5a, 32'(u_flash_device_model.peek(32'h60000)));
    run(flash_seq_pkg::OP_RESUME, 19'h40000, 8'h0, 0);
    check("resumed", 32'h0, 32'(rd[`STAT_SUSP]));
    check("resume_erased", 32'hff, 32'(u_flash_device_model.peek(32'h40020)));
    $display("test suspend and resume done");
    order(flash_seq_pkg::OP_RESUME, 19'h0, 8'h0);
    apb(0, `REG_STATUS, 32'h0);
    check("resume_reject", 32'h1, 32'(rd[`STAT_REJECT]));
    run(flash_seq_pkg::OP_READ, 19'h0, 8'h0, 0);
    check("reject_clear", 32'h0, 32'(rd[`STAT_REJECT]));
    order(flash_seq_pkg::OP_SUSPEND, 19'h0, 8'h0);
    apb(0, `REG_STATUS, 32'h0);
    check("suspend_reject", 32'h1, 32'(rd[`STAT_REJECT]));
    fail_mode <= 1;
    run(flash_seq_pkg::OP_PROGRAM, 19'h50000, 8'h66, 1);
    check("timeout", 32'h1, 32'(rd[`STAT_TIMEOUT]));
    run(flash_seq_pkg::OP_RESET, 19'h0, 8'h0, 0);
    check("reset_idle", 32'h1, 32'(u_flash_device_model.idle));
    fail_mode <= 0;
    $display("test refusals and timeout done");
    final_report();
  end
endmodule : flash_erase_program_sequencer_bench
bind flash_erase_program_sequencer flash_seq_properties #(.WINDOW_CYC(WINDOW_CYC))
  u_flash_seq_properties (.sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins(pins), .dq_in(dq_in));
